// >>> common/jtg_pkg.sv
// Purpose: Shared constants and types for the test port register block.
// Assumes: One sampling clock; the test clock arrives as a plain pin.
// Notes:   Chain lengths, instruction codes and cell layout live here.
`default_nettype none
package jtg_pkg;
    // ------------------------------------------------------------------
    // Chain widths
    // ------------------------------------------------------------------
    localparam int IR_W   = 4;
    localparam int ID_W   = 32;
    localparam int DBG_W  = 35;
    localparam int NPAD   = 8;           // General-purpose pins on the chain.
    localparam int CELL_N = 3;           // Cells per pin.
    localparam int CELL_I = 0;           // Input cell position within a pin.
    localparam int CELL_O = 1;           // Output cell position within a pin.
    localparam int CELL_E = 2;           // Output enable cell position.
    localparam int BS_RST = CELL_N * NPAD;   // Observe-only reset cell.
    localparam int BS_W   = BS_RST + 1;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_INTEST = 4'h1;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] IR_ABORT  = 4'h8;
    localparam logic [IR_W-1:0] IR_DPACC  = 4'ha;
    localparam logic [IR_W-1:0] IR_APACC  = 4'hb;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'he;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPT   = 4'h1;   // Fixed capture pattern.

    // Arbitrary identification word; bit 0 is forced to one anyway.
    localparam logic [ID_W-1:0] ID_DEF    = 32'h0123_4001;

    // Debug chain numbers, also the select code driven to the access port.
    localparam int DBG_N = 3;
    localparam logic [1:0] DSEL_ABORT = 2'h0;
    localparam logic [1:0] DSEL_DP    = 2'h1;
    localparam logic [1:0] DSEL_AP    = 2'h2;

    typedef enum logic [3:0] {
        TAP_RESET = 4'b0000, TAP_IDLE  = 4'b0001, TAP_SELDR = 4'b0010,
        TAP_CAPDR = 4'b0011, TAP_SHDR  = 4'b0100, TAP_EX1DR = 4'b0101,
        TAP_PADR  = 4'b0110, TAP_EX2DR = 4'b0111, TAP_UPDR  = 4'b1000,
        TAP_SELIR = 4'b1001, TAP_CAPIR = 4'b1010, TAP_SHIR  = 4'b1011,
        TAP_EX1IR = 4'b1100, TAP_PAIR  = 4'b1101, TAP_EX2IR = 4'b1110,
        TAP_UPIR  = 4'b1111
    } jtg_tap_t;
endpackage
`default_nettype wire

// >>> verilog/jtg_regs.sv
// Purpose: Instruction and data register chains of the test access port.
// Assumes: mclk runs at least eight times faster than tck.
// Notes:   All pins are synchronised; tck edges are found by sampling.
//
// How it works
// - Four-bit instruction shift chain with a parallel holding register.
// - Only Update-IR and Test-Logic-Reset change the active instruction; shifting never does.
// - Codes 0000, 0001, 0010 select the boundary chain.
// - Codes 1000, 1010, 1011 select the abort, DP and AP chains.
// - Code 1110 selects identification, 1111 a one-bit bypass stage.
// - Any unlisted code behaves exactly like bypass.
// - External test drives pads from held output and enable cells.
// - Internal test feeds core inputs from held input cells.
// - System reset is an observe-only cell, never overridden.
// - Boundary chain stays capturable and shiftable under both test modes.
// - Sample/preload captures pad input, output, enable at Capture-DR.
// - Shift-DR moves one bit per tck, out on tdo, in from tdi.
// - Entering Update-DR copies the boundary chain into holding cells.
// - Three cells per pin: input, output, enable, from the port side.
// - Identification becomes active on reset, trst, and Test-Logic-Reset.
// - Identification chain is 32 bits with bit zero always one.
// - Bypass chain is one bit and captures zero.
// - Identification chain shifts out the fixed identification word.
// - Abort, DP and AP chains are 35 bits each.
// - Abort chain data goes to the access port to clear flags.
// - DP and AP chains read and write the access port registers.
// - No chain is reachable except serially through the test port.
`timescale 1ns/10ps
`default_nettype none

module jtg_regs #(
    parameter logic [jtg_pkg::ID_W-1:0] ID_CODE = jtg_pkg::ID_DEF  // Arbitrary value.
) (
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    input  wire logic                     trstN,
    output logic                          tdo,
    output logic                          tdoOeN,
    input  wire logic [jtg_pkg::NPAD-1:0] padIn,
    output logic      [jtg_pkg::NPAD-1:0] padOut,
    output logic      [jtg_pkg::NPAD-1:0] padOeN,
    input  wire logic                     sysRstN,
    input  wire logic [jtg_pkg::NPAD-1:0] coreOut,
    input  wire logic [jtg_pkg::NPAD-1:0] coreOe,
    output logic      [jtg_pkg::NPAD-1:0] coreIn,
    input  wire logic [jtg_pkg::DBG_W-1:0] accRdata,
    output logic      [jtg_pkg::DBG_W-1:0] accWdata,
    output logic      [1:0]               accSel,
    output logic                          accWrite
);
    import jtg_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // All pins share one depth so tck, tms and tdi stay aligned.
    localparam int SW = 4 + NPAD + 1;
    logic [SW-1:0] syncA_r;
    logic [SW-1:0] syncB_r;
    logic          tckPrev_r;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            // The tck bits rest at its idle high level, so no false edge follows reset.
            syncA_r   <= SW'(1);
            syncB_r   <= SW'(1);
            tckPrev_r <= 1'b1;
        end else begin
            syncA_r   <= {sysRstN, padIn, trstN, tdi, tms, tck};
            syncB_r   <= syncA_r;
            tckPrev_r <= syncB_r[0];
        end
    end

    wire            tckS    = syncB_r[0];
    wire            tmsS    = syncB_r[1];
    wire            tdiS    = syncB_r[2];
    wire            trstS   = ~syncB_r[3];
    wire [NPAD-1:0] padInS  = syncB_r[4 +: NPAD];
    wire            sysRstS = syncB_r[SW-1];
    wire            tckRise = tckS & ~tckPrev_r;
    wire            tckFall = ~tckS & tckPrev_r;

    // ------------------------------------------------------------------
    // Test access port state
    // ------------------------------------------------------------------
    jtg_tap_t tap_r;
    jtg_tap_t tap_nxt;

    // Standard sixteen-state walk, stepped only on a sampled rising edge.
    always_comb begin
        tap_nxt = tap_r;
        case (tap_r)
            TAP_RESET: tap_nxt = tmsS ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:  tap_nxt = tmsS ? TAP_SELDR : TAP_IDLE;
            TAP_SELDR: tap_nxt = tmsS ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: tap_nxt = tmsS ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR:  tap_nxt = tmsS ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: tap_nxt = tmsS ? TAP_UPDR  : TAP_PADR;
            TAP_PADR:  tap_nxt = tmsS ? TAP_EX2DR : TAP_PADR;
            TAP_EX2DR: tap_nxt = tmsS ? TAP_UPDR  : TAP_SHDR;
            TAP_UPDR:  tap_nxt = tmsS ? TAP_SELDR : TAP_IDLE;
            TAP_SELIR: tap_nxt = tmsS ? TAP_RESET : TAP_CAPIR;
            TAP_CAPIR: tap_nxt = tmsS ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR:  tap_nxt = tmsS ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: tap_nxt = tmsS ? TAP_UPIR  : TAP_PAIR;
            TAP_PAIR:  tap_nxt = tmsS ? TAP_EX2IR : TAP_PAIR;
            TAP_EX2IR: tap_nxt = tmsS ? TAP_UPIR  : TAP_SHIR;
            TAP_UPIR:  tap_nxt = tmsS ? TAP_SELDR : TAP_IDLE;
            default:   tap_nxt = TAP_RESET;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tap_r <= TAP_RESET;
        end else if (trstS) begin
            tap_r <= TAP_RESET;
        end else if (tckRise) begin
            tap_r <= tap_nxt;
        end
    end

    // Actions on a sampled rising edge, keyed on the state being left; updates are keyed on the state being entered.
    wire capDr = tckRise & (tap_r == TAP_CAPDR);
    wire shDr  = tckRise & (tap_r == TAP_SHDR);
    wire upDr  = tckRise & (tap_r != TAP_UPDR) & (tap_nxt == TAP_UPDR);
    wire capIr = tckRise & (tap_r == TAP_CAPIR);
    wire shIr  = tckRise & (tap_r == TAP_SHIR);
    wire upIr  = tckRise & (tap_r != TAP_UPIR) & (tap_nxt == TAP_UPIR);
    wire tlr   = trstS | (tap_r == TAP_RESET);

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    logic [IR_W-1:0] irSh_r;
    logic [IR_W-1:0] ir_r;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irSh_r <= IR_IDCODE;
            ir_r   <= IR_IDCODE;
        end else begin
            if (capIr) begin
                irSh_r <= IR_CAPT;
            end else if (shIr) begin
                irSh_r <= {tdiS, irSh_r[IR_W-1:1]};
            end
            if (tlr) begin
                ir_r <= IR_IDCODE;
            end else if (upIr) begin
                ir_r <= irSh_r;
            end
        end
    end

    // Decode; anything unlisted falls to bypass so tdo always has a path.
    wire isExt = (ir_r == IR_EXTEST);
    wire isInt = (ir_r == IR_INTEST);
    wire isBs  = isExt | isInt | (ir_r == IR_SAMPLE);
    wire isAb  = (ir_r == IR_ABORT);
    wire isDp  = (ir_r == IR_DPACC);
    wire isAp  = (ir_r == IR_APACC);
    wire isId  = (ir_r == IR_IDCODE);
    wire isDbg = isAb | isDp | isAp;
    wire isByp = ~(isBs | isDbg | isId);
    wire [DBG_N-1:0] dbgOn = {isAp, isDp, isAb};

    // ------------------------------------------------------------------
    // Identification and bypass chains
    // ------------------------------------------------------------------
    logic [ID_W-1:0] idSh_r;
    logic            bypSh_r;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            idSh_r  <= '0;
            bypSh_r <= 1'b0;
        end else begin
            if (capDr && isId) begin
                idSh_r <= {ID_CODE[ID_W-1:1], 1'b1};
            end else if (shDr && isId) begin
                idSh_r <= {tdiS, idSh_r[ID_W-1:1]};
            end
            if (capDr && isByp) begin
                bypSh_r <= 1'b0;
            end else if (shDr && isByp) begin
                bypSh_r <= tdiS;
            end
        end
    end

    // ------------------------------------------------------------------
    // Debug access chains
    // ------------------------------------------------------------------
    // Fields inside the words are the access port's business; the chains
    // only carry them, which keeps this block independent of that format.
    logic [DBG_W-1:0] dbgSh_r [DBG_N];

    for (genvar c = 0; c < DBG_N; c++) begin : g_dbg
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                dbgSh_r[c] <= '0;
            end else if (capDr && dbgOn[c]) begin
                dbgSh_r[c] <= accRdata;
            end else if (shDr && dbgOn[c]) begin
                dbgSh_r[c] <= {tdiS, dbgSh_r[c][DBG_W-1:1]};
            end
        end
    end

    wire [1:0] dselNxt = isAb ? DSEL_ABORT : (isDp ? DSEL_DP : DSEL_AP);
    wire [DBG_W-1:0] dbgCur = isAb ? dbgSh_r[0] : (isDp ? dbgSh_r[1] : dbgSh_r[2]);

    // One-cycle write pulse with the word and chain held until the next one.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            accWdata <= '0;
            accSel   <= DSEL_ABORT;
            accWrite <= 1'b0;
        end else begin
            accWrite <= upDr & isDbg;
            if (upDr && isDbg) begin
                accWdata <= dbgCur;
                accSel   <= dselNxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Boundary chain
    // ------------------------------------------------------------------
    logic [BS_W-1:0] bsSh_r;
    logic [BS_W-1:0] bsHold_r;
    wire  [BS_W-1:0] bsCap;
    logic [NPAD-1:0] padOe_r;     // Active-high copy of what drives the pad.

    // Pin 0 sits next to the port pins and lands nearest tdo.
    for (genvar p = 0; p < NPAD; p++) begin : g_cell
        assign bsCap[CELL_N*p + CELL_I] = padInS[p];
        assign bsCap[CELL_N*p + CELL_O] = padOut[p];
        assign bsCap[CELL_N*p + CELL_E] = padOe_r[p];
    end
    assign bsCap[BS_RST] = sysRstS;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bsSh_r   <= '0;
            bsHold_r <= '0;
        end else begin
            if (capDr && isBs) begin
                bsSh_r <= bsCap;
            end else if (shDr && isBs) begin
                bsSh_r <= {tdiS, bsSh_r[BS_W-1:1]};
            end
            if (upDr && isBs) begin
                bsHold_r <= bsSh_r;
            end
        end
    end

    // Pad and core muxes; the reset cell's held bit drives nothing at all.
    for (genvar p = 0; p < NPAD; p++) begin : g_pad
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                padOut[p]  <= 1'b0;
                padOe_r[p] <= 1'b0;
                padOeN[p]  <= 1'b1;
                coreIn[p]  <= 1'b0;
            end else begin
                padOut[p]  <= isExt ? bsHold_r[CELL_N*p + CELL_O] : coreOut[p];
                padOe_r[p] <= isExt ? bsHold_r[CELL_N*p + CELL_E] : coreOe[p];
                padOeN[p]  <= ~(isExt ? bsHold_r[CELL_N*p + CELL_E] : coreOe[p]);
                coreIn[p]  <= isInt ? bsHold_r[CELL_N*p + CELL_I] : padInS[p];
            end
        end
    end

    // ------------------------------------------------------------------
    // Test data out
    // ------------------------------------------------------------------
    // The selected chain's low bit goes out on the falling edge, giving
    // the tester half a tck period, less the synchroniser delay, of setup before its next rising edge.
    wire drBit = isBs ? bsSh_r[0] : (isDbg ? dbgCur[0] : (isId ? idSh_r[0] : bypSh_r));
    wire inSh  = (tap_r == TAP_SHDR) | (tap_r == TAP_SHIR);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tdo    <= 1'b0;
            tdoOeN <= 1'b1;
        end else if (tckFall) begin
            tdo    <= (tap_r == TAP_SHIR) ? irSh_r[0] : drBit;
            tdoOeN <= ~inSh;
        end
    end
endmodule

`default_nettype wire

// >>> verification/jtg_regs_properties.sv
// Purpose: Port-level timing properties of the test register block.
// Assumes: tck is a slow pin sampled by mclk through synchronisers.
// Notes:   Windows of two to four mclk allow for synchroniser latency.
`timescale 1ns/10ps
`default_nettype none
module jtg_regs_chk (
    input wire logic                      mclk,
    input wire logic                      reset,
    input wire logic                      tck,
    input wire logic                      trstN,
    input wire logic                      tdo,
    input wire logic                      tdoOeN,
    input wire logic [jtg_pkg::DBG_W-1:0] accWdata,
    input wire logic [1:0]                accSel,
    input wire logic                      accWrite
);
    import jtg_pkg::*;
    // ----------------------------------------------------------------
    // Recent tck samples, so edges can be placed in time
    // ----------------------------------------------------------------
    logic [4:0] tckH_r;
    logic       fallSeen;
    logic       riseSeen;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tckH_r <= 5'h0;
        end else begin
            tckH_r <= {tckH_r[3:0], tck};
        end
    end
    // A zero history after reset can only widen the windows, never fire them.
    assign fallSeen = |(tckH_r[4:2] & ~tckH_r[3:1]);
    assign riseSeen = |(~tckH_r[4:2] & tckH_r[3:1]);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_trst_held;
        !trstN [*6];
    endsequence
    sequence s_one_pulse;
        accWrite ##1 !accWrite;
    endsequence
    a_tdo_on_fall: assert property ($changed(tdo) |-> fallSeen)
        else $error("tdo moved away from a tck fall");
    a_oe_on_fall: assert property ($changed(tdoOeN) |-> fallSeen)
        else $error("tdo enable moved away from a tck fall");
    a_write_single: assert property (accWrite |-> s_one_pulse)
        else $error("write strobe longer than one cycle");
    a_write_on_rise: assert property (accWrite |-> riseSeen)
        else $error("write strobe not after a tck rise");
    a_write_oe_off: assert property (accWrite |-> tdoOeN)
        else $error("write strobe while tdo driven");
    a_sel_with_write: assert property ($changed(accSel) |-> accWrite)
        else $error("chain select changed without a write");
    a_wdata_with_write: assert property ($changed(accWdata) |-> accWrite)
        else $error("write word changed without a write");
    a_sel_legal: assert property (accSel != 2'h3)
        else $error("illegal chain select");
    a_trst_quiet: assert property (s_trst_held |-> !accWrite)
        else $error("write strobe during test reset");
endmodule
bind jtg_regs jtg_regs_chk jtg_regs_chk_inst (.mclk(mclk), .reset(reset), .tck(tck),
    .trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN), .accWdata(accWdata), .accSel(accSel),
    .accWrite(accWrite));
`default_nettype wire

// >>> verification/jtg_tester.sv
// Purpose: Behavioural test probe that drives the test port pins.
// Assumes: One tck period is eight mclk; tck rests high between scans.
// Notes:   Pins change only at falling mclk, so sampling never races.
`timescale 1ns/10ps
`default_nettype none
module jtg_tester (
    input  wire logic mclk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One tck period: fall with new tms and tdi, sample tdo, then rise.
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge mclk);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(negedge mclk);
        o = tdo;
        tck = 1'b1;
        repeat (3) @(negedge mclk);
    endtask
    // Five high tms rises reach Test-Logic-Reset, then rest in Run-Idle.
    task automatic tlr_idle();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
    // Whole scan from Run-Idle back to Run-Idle, LSB first both ways.
    task automatic scan(input bit ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic o;
        dout = 64'h0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule
`default_nettype wire

// >>> verification/test_jtg_regs.sv
// Purpose: Self-checking bench for the test port register chains.
// Assumes: Expected words are built here from the chain layout.
// Notes:   Random pad, core and access port values come from one seed.
`timescale 1ns/10ps
`default_nettype none
module test_jtg_regs;
    import jtg_pkg::*;
    logic             mclk, reset, tck, tms, tdi, trstN, tdo, tdoOeN, sysRstN, accWrite, bitOut;
    logic [NPAD-1:0]  padIn, padOut, padOeN, coreOut, coreOe, coreIn;
    logic [DBG_W-1:0] accRdata, accWdata;
    logic [1:0]       accSel;
    logic [63:0]      dout, din, din2;
    int               miscompares, totalChecks;
    int               oeLow, wrCnt;
    logic [3:0]       byCode [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd, 4'hf};
    logic [3:0]       dbgCode [3] = '{IR_ABORT, IR_DPACC, IR_APACC};
    logic [1:0]       dbgSel [3] = '{DSEL_ABORT, DSEL_DP, DSEL_AP};
    // ----------------------------------------------------------------
    // Design, probe and clock
    // ----------------------------------------------------------------
    jtg_regs jtg_regs_inst (.mclk(mclk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
        .trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN), .padIn(padIn), .padOut(padOut),
        .padOeN(padOeN), .sysRstN(sysRstN), .coreOut(coreOut), .coreOe(coreOe),
        .coreIn(coreIn), .accRdata(accRdata), .accWdata(accWdata), .accSel(accSel),
        .accWrite(accWrite));
    jtg_tester jtg_tester_inst (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    always #50 mclk = ~mclk;
    // Tdo enable time and write strobes are counted, so a scan can check how long
    // the pin was driven and that exactly one strobe left the chain.
    always @(negedge mclk) begin
        if (tdoOeN === 1'b0) oeLow++;
        if (accWrite === 1'b1) wrCnt++;
    end
    // Counted comparison; a stuck unknown never passes.
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Boundary word expected at capture for given pad output and enable.
    function automatic logic [63:0] capt(input logic [NPAD-1:0] o, input logic [NPAD-1:0] e);
        capt = 64'h0;
        for (int p = 0; p < NPAD; p++) begin
            capt[CELL_N*p+CELL_I] = padIn[p];
            capt[CELL_N*p+CELL_O] = o[p];
            capt[CELL_N*p+CELL_E] = e[p];
        end
        capt[BS_RST] = sysRstN;
    endfunction
    function automatic logic [NPAD-1:0] cells(input logic [63:0] v, input int c);
        for (int p = 0; p < NPAD; p++) cells[p] = v[CELL_N*p+c];
    endfunction
    task automatic ir(input logic [3:0] code);
        jtg_tester_inst.scan(1'b1, IR_W, {60'h0, code}, dout);
        chk("instruction capture", {60'h0, IR_CAPT}, dout);
    endtask
    task automatic readId(input string what);
        oeLow = 0;
        jtg_tester_inst.scan(1'b0, ID_W, 64'h0, dout);
        chk(what, {32'h0, ID_DEF | 32'h1}, dout);
        chk("tdo enable span", 64'(8 * ID_W), 64'(oeLow));
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog sized well above the few thousand cycles the tests need.
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        giveVerdict();
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0; reset = 1'b1; trstN = 1'b1; sysRstN = 1'b1;
        padIn = 8'h00; coreOut = 8'h00; coreOe = 8'h00; accRdata = 35'h0;
        miscompares = 0; totalChecks = 0;
        void'($urandom(32'h2c5fb08e));
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        repeat (3) @(negedge mclk);
        jtg_tester_inst.tlr_idle();
        readId("identity after reset");
        $display("test identity done");
        foreach (byCode[k]) begin
            ir(byCode[k]);
            din = 64'($urandom) & 64'h3;
            jtg_tester_inst.scan(1'b0, 2, din, dout);
            chk("bypass path", {62'h0, din[0], 1'b0}, dout);
        end
        $display("test bypass done");
        for (int k = 0; k < DBG_N; k++) begin
            ir(dbgCode[k]);
            accRdata = DBG_W'({$urandom, $urandom});
            din = 64'({$urandom, $urandom}) & ((64'h1 << DBG_W) - 1);
            wrCnt = 0;
            jtg_tester_inst.scan(1'b0, DBG_W, din, dout);
            chk("debug capture", {29'h0, accRdata}, dout);
            chk("debug write", din, {29'h0, accWdata});
            chk("debug select", {62'h0, dbgSel[k]}, {62'h0, accSel});
            chk("write strobes", 64'h1, 64'(wrCnt));
        end
        $display("test debug chains done");
        padIn = NPAD'($urandom); coreOut = NPAD'($urandom); coreOe = NPAD'($urandom);
        sysRstN = 1'($urandom);
        ir(IR_SAMPLE);
        din = 64'({$urandom, $urandom}) & ((64'h1 << BS_W) - 1);
        jtg_tester_inst.scan(1'b0, BS_W, din, dout);
        chk("sample capture", capt(coreOut, coreOe), dout);
        chk("core in pass", {56'h0, padIn}, {56'h0, coreIn});
        chk("pad enable pass", {56'h0, ~coreOe}, {56'h0, padOeN});
        ir(IR_EXTEST);
        chk("pad out", {56'h0, cells(din, CELL_O)}, {56'h0, padOut});
        chk("pad enable", {56'h0, ~cells(din, CELL_E)}, {56'h0, padOeN});
        din2 = 64'({$urandom, $urandom}) & ((64'h1 << BS_W) - 1);
        jtg_tester_inst.scan(1'b0, BS_W, din2, dout);
        chk("extest capture", capt(cells(din, CELL_O), cells(din, CELL_E)), dout);
        chk("pad out reload", {56'h0, cells(din2, CELL_O)}, {56'h0, padOut});
        ir(IR_INTEST);
        chk("core in", {56'h0, cells(din2, CELL_I)}, {56'h0, coreIn});
        $display("test boundary done");
        ir(IR_BYPASS);
        trstN = 1'b0;
        repeat (8) @(negedge mclk);
        trstN = 1'b1;
        repeat (3) @(negedge mclk);
        jtg_tester_inst.step(1'b0, 1'b0, bitOut);
        readId("identity after test reset");
        ir(IR_BYPASS);
        jtg_tester_inst.tlr_idle();
        readId("identity after tms reset");
        $display("test resets done");
        giveVerdict();
    end
endmodule
`default_nettype wire
